/* common/fi2c_pkg.sv */
package fi2c_pkg;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_HZ       = 10_000_000;
    localparam int T_PROG_US    = 110;
    localparam int T_SERASE_MS  = 501;
    localparam int T_FERASE_MS  = 1002;
    // Longest times, rounded down to whole cycles
    localparam int PROG_CYC     = T_PROG_US * (CLK_HZ / 1_000_000);
    localparam int SERASE_CYC   = T_SERASE_MS * (CLK_HZ / 1_000);
    localparam int FERASE_CYC   = T_FERASE_MS * (CLK_HZ / 1_000);
    localparam int BUSY_W       = 24;

    // ************************************************************
    // Two-wire protocol
    // ************************************************************
    localparam logic [3:0] SLV_HI_DEF  = 4'ha;
    localparam int         PAGE_BYTES  = 16;
    localparam logic [2:0] FULL_TRIG   = 3'h7;
    localparam logic [7:0] ERASED_BYTE = 8'hff;

    // ************************************************************
    // APB register map
    // ************************************************************
    localparam logic [11:0] ADDR_CTRL   = 12'h000;
    localparam logic [11:0] ADDR_STAT   = 12'h004;
    localparam int          CTRL_EN     = 0;
    localparam int          CTRL_FULL   = 1;
    localparam logic        CTRL_EN_RST = 1'b1;
    localparam int          STAT_BUSY   = 0;
    localparam int          STAT_BUS    = 1;
    localparam int          STAT_PTR    = 8;

    // Erase method chosen at build time
    typedef enum logic [1:0] {
        ER_FULL = 2'h0,
        ER_BYTE = 2'h1,
        ER_A2   = 2'h2,
        ER_NONE = 2'h3
    } fi2c_erase_t;

    // Flash operations
    typedef enum logic [1:0] {
        FOP_NONE    = 2'h0,
        FOP_PROG    = 2'h1,
        FOP_ERS_SEC = 2'h2,
        FOP_ERS_ALL = 2'h3
    } fi2c_fop_t;

endpackage

/* common/fi2c_flash_if.sv */
`timescale 1ns/1ps
interface fi2c_flash_if #(parameter int AW = 8);
    logic            req;
    fi2c_pkg::fi2c_fop_t op;
    logic [AW-1:0]   addr;
    logic [7:0]      wdata;
    logic            busy;
    logic [AW-1:0]   raddr;
    logic [7:0]      rdata;

    modport ctl (output req, op, addr, wdata, raddr, input busy, rdata);
    modport mem (input req, op, addr, wdata, raddr, output busy, rdata);
endinterface

/* core/fi2c_flash.sv */
`timescale 1ns/1ps
module fi2c_flash import fi2c_pkg::*; #(
    parameter int MEM_BYTES  = 256,
    parameter int AW         = 8,
    parameter int SERASE_CYC = fi2c_pkg::SERASE_CYC,
    parameter int FERASE_CYC = fi2c_pkg::FERASE_CYC
) (
    // Clock and reset
    input wire logic   pclk,
    input wire logic   presetn,
    // Controller side
    fi2c_flash_if.mem  fl
);

    // ************************************************************
    // User flash array
    // ************************************************************
    logic [7:0]        user_flash_array [MEM_BYTES];
    logic [BUSY_W-1:0] busy_q;
    logic [7:0]        rdata_q;

    // Busy covers the request cycle too, so the controller never races it
    assign fl.busy  = (busy_q != '0) | fl.req;
    assign fl.rdata = rdata_q;

    // Cycle time of the running operation
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_q <= '0;
        end else if (fl.req) begin
            unique case (fl.op)
                FOP_PROG:    busy_q <= BUSY_W'(PROG_CYC);
                FOP_ERS_SEC: busy_q <= BUSY_W'(SERASE_CYC);
                FOP_ERS_ALL: busy_q <= BUSY_W'(FERASE_CYC);
                default:     busy_q <= '0;
            endcase
        end else if (busy_q != '0) begin
            busy_q <= busy_q - BUSY_W'(1);
        end
    end

    // Array contents; program only clears bits like real flash
    always_ff @(posedge pclk) begin
        if (fl.req) begin
            for (int i = 0; i < MEM_BYTES; i++) begin
                if (fl.op == FOP_ERS_ALL ||
                    (fl.op == FOP_ERS_SEC && (i >= MEM_BYTES / 2) == fl.addr[AW-1])) begin
                    user_flash_array[i] <= ERASED_BYTE;
                end
            end
            if (fl.op == FOP_PROG) begin
                user_flash_array[fl.addr] <= user_flash_array[fl.addr] & fl.wdata;
            end
        end
        rdata_q <= user_flash_array[fl.raddr];
    end

endmodule

/* core/fi2c_slave.sv */
`timescale 1ns/1ps
// Functional notes
// - Write address match acknowledged on ninth clock
// - Memory address and data bytes each acknowledged
// - Programming starts only after stop condition
// - Page write holds at most sixteen bytes
// - Busy device ignores transfers, no address acknowledge
// - Write guard blocks upper half or all
// - Guarded write: acknowledge addresses, refuse first data
// - One erase method fixed at build time
// - Read-only build has no erase at all
// - Address low bits 111 select full erase
// - Full erase starts after stop, polled
// - Guarded full erase trigger address not acknowledged
// - Trigger byte address erases sector then programs
// - Trigger defaults zero and half memory size
// - Address bit two selects sector erase
// - Bit-two erase names sector, starts after stop
// - Guarded bit-two erase refuses the byte address
// - Larger memories take address bits from slave
// - Reads use pointer, incremented after every byte
// - Random read: dummy write then repeated start
// - Sequential read continues while master acknowledges
// - Slave address: fixed nibble, pins, direction bit
module fi2c_slave import fi2c_pkg::*; #(
    parameter int          MEM_BYTES  = 256,
    parameter fi2c_erase_t ERASE_MODE = ER_FULL,
    parameter bit          READ_ONLY  = 1'b0,
    parameter bit          WP_FULL    = 1'b0,
    parameter logic [3:0]  SLV_HI     = SLV_HI_DEF,
    parameter int          TRIG0      = 0,
    parameter int          TRIG1      = MEM_BYTES / 2,
    parameter int          SERASE_CYC = fi2c_pkg::SERASE_CYC,
    parameter int          FERASE_CYC = fi2c_pkg::FERASE_CYC
) (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Two-wire bus pins
    input  wire logic        scl_i,
    input  wire logic        sda_i,
    output logic             sda_o,
    output logic             sda_oe,
    // Straps
    input  wire logic        wp_i,
    input  wire logic [2:0]  dev_addr_i
);

    localparam int AW = $clog2(MEM_BYTES);
    localparam fi2c_erase_t EMODE = READ_ONLY ? ER_NONE : ERASE_MODE;
    // Slave address bits used as device bits: A2 mode and large sizes drop some
    localparam logic [2:0] DEV_MASK = {EMODE != ER_A2, AW < 10, AW < 9};
    localparam logic [1:0] HI_MASK  = {AW >= 10, AW >= 9};

    typedef enum logic [5:0] {
        B_IDLE = 6'h01,
        B_DEV  = 6'h02,
        B_MEM  = 6'h04,
        B_WDAT = 6'h08,
        B_RDAT = 6'h10,
        B_IGN  = 6'h20
    } fi2c_bus_t;

    fi2c_flash_if #(.AW(AW)) fl ();

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    logic [5:0] s1_q, s2_q, s3_q, filt_q;
    logic       scl_p_q, sda_p_q;
    logic       scl_f, sda_f, wp_f, scl_rise, scl_fall, start_c, stop_c;
    logic [2:0] pins_f;

    // Three stages; a bit rises once the last two are both high and falls as soon as they differ
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_q    <= 6'h3f;
            s2_q    <= 6'h3f;
            s3_q    <= 6'h3f;
            filt_q  <= 6'h3f;
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
        end else begin
            s1_q    <= {scl_i, sda_i, wp_i, dev_addr_i};
            s2_q    <= s1_q;
            s3_q    <= s2_q;
            filt_q  <= (s2_q & s3_q) | (filt_q & ~(s2_q ^ s3_q));
            scl_p_q <= scl_f;
            sda_p_q <= sda_f;
        end
    end

    assign {scl_f, sda_f, wp_f, pins_f} = filt_q;
    assign scl_rise = scl_f & ~scl_p_q;
    assign scl_fall = ~scl_f & scl_p_q;
    assign start_c  = scl_f & scl_p_q & sda_p_q & ~sda_f;
    assign stop_c   = scl_f & scl_p_q & ~sda_p_q & sda_f;

    // ************************************************************
    // Decode helpers
    // ************************************************************
    function automatic logic dev_hit(input logic [7:0] b, input logic [2:0] pins);
        return b[7:4] == SLV_HI && ((b[3:1] ^ pins) & DEV_MASK) == 3'h0;
    endfunction

    function automatic logic [AW-1:0] mk_addr(input logic [1:0] hi, input logic [7:0] lo);
        logic [9:0] full;
        full = {hi, lo};
        return full[AW-1:0];
    endfunction

    // ************************************************************
    // Registers
    // ************************************************************
    fi2c_bus_t     st_q;
    logic [3:0]    bit_q;
    logic [7:0]    sh_q, tx_q;
    logic          sda_oe_q, mack_q, rd_q, a2ers_q;
    logic [1:0]    ahi_q;
    logic [AW-1:0] ptr_q, base_q;
    logic [4:0]    cnt_q;
    logic [7:0]    buf_q [PAGE_BYTES];
    fi2c_fop_t     ers_op_q;
    logic          ers_sec_q;
    logic          en_q, full_q, seq_act_q;
    logic          busy_c, prot_c, dev_rw, dev_fe, fe_ok;

    assign busy_c = seq_act_q;
    // Write guard: whole array or upper half only
    assign prot_c = READ_ONLY || (wp_f && (full_q || ptr_q[AW-1]));
    assign dev_rw = en_q && !busy_c && dev_hit(sh_q, pins_f);
    assign dev_fe = en_q && !busy_c && EMODE == ER_FULL && !sh_q[0] &&
                    sh_q[7:4] == SLV_HI && sh_q[3:1] == FULL_TRIG;
    assign fe_ok  = dev_fe && !wp_f;

    // ************************************************************
    // Bus state machine
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q      <= B_IDLE;
            bit_q     <= 4'h0;
            sh_q      <= 8'h00;
            tx_q      <= 8'h00;
            sda_oe_q  <= 1'b0;
            mack_q    <= 1'b0;
            rd_q      <= 1'b0;
            a2ers_q   <= 1'b0;
            ahi_q     <= 2'h0;
            ptr_q     <= '0;
            base_q    <= '0;
            cnt_q     <= 5'h00;
            ers_op_q  <= FOP_NONE;
            ers_sec_q <= 1'b0;
        end else if (start_c) begin
            // A repeated start drops any unfinished write
            st_q     <= B_DEV;
            bit_q    <= 4'h0;
            sda_oe_q <= 1'b0;
            cnt_q    <= 5'h00;
            ers_op_q <= FOP_NONE;
        end else if (stop_c) begin
            // Pending work is handed to the sequencer on this edge
            st_q     <= B_IDLE;
            bit_q    <= 4'h0;
            sda_oe_q <= 1'b0;
            cnt_q    <= 5'h00;
            ers_op_q <= FOP_NONE;
        end else if (scl_rise && !st_q[0] && st_q != B_IGN) begin
            if (bit_q < 4'h8) begin
                sh_q <= {sh_q[6:0], sda_f};
            end else begin
                mack_q <= ~sda_f;
            end
            bit_q <= bit_q + 4'h1;
        end else if (scl_fall) begin
            unique case (st_q)
                B_DEV: begin
                    if (bit_q == 4'h8) begin
                        rd_q     <= sh_q[0];
                        ahi_q    <= sh_q[2:1] & HI_MASK;
                        a2ers_q  <= EMODE == ER_A2 && sh_q[3] && !sh_q[0];
                        sda_oe_q <= dev_rw || fe_ok;
                        if (fe_ok && !dev_rw) begin
                            ers_op_q <= FOP_ERS_ALL;
                        end
                    end else if (bit_q == 4'h9) begin
                        bit_q <= 4'h0;
                        if (!sda_oe_q || (ers_op_q == FOP_ERS_ALL)) begin
                            sda_oe_q <= 1'b0;
                            st_q     <= B_IGN;
                        end else if (rd_q) begin
                            // Current-address read starts from the pointer
                            tx_q     <= fl.rdata;
                            sda_oe_q <= ~fl.rdata[7];
                            st_q     <= B_RDAT;
                        end else begin
                            sda_oe_q <= 1'b0;
                            st_q     <= B_MEM;
                        end
                    end
                end
                B_MEM: begin
                    if (bit_q == 4'h8) begin
                        ptr_q    <= mk_addr(ahi_q, sh_q);
                        base_q   <= mk_addr(ahi_q, sh_q);
                        // Guarded sector erase refuses the byte address
                        sda_oe_q <= !(a2ers_q && (READ_ONLY || (wp_f && (full_q ||
                                    mk_addr(ahi_q, sh_q) >= AW'(MEM_BYTES / 2)))));
                        if (a2ers_q) begin
                            ers_op_q  <= FOP_ERS_SEC;
                            ers_sec_q <= mk_addr(ahi_q, sh_q) >= AW'(MEM_BYTES / 2);
                        end
                    end else if (bit_q == 4'h9) begin
                        bit_q    <= 4'h0;
                        st_q     <= (sda_oe_q && !a2ers_q) ? B_WDAT : B_IGN;
                        sda_oe_q <= 1'b0;
                        if (!sda_oe_q) begin
                            ers_op_q <= FOP_NONE;
                        end
                    end
                end
                B_WDAT: begin
                    if (bit_q == 4'h8) begin
                        if (prot_c || cnt_q == 5'(PAGE_BYTES)) begin
                            sda_oe_q <= 1'b0;
                        end else begin
                            sda_oe_q       <= 1'b1;
                            buf_q[cnt_q[3:0]] <= sh_q;
                            cnt_q          <= cnt_q + 5'h01;
                            ptr_q          <= ptr_q + AW'(1);
                            if (EMODE == ER_BYTE && cnt_q == 5'h00 &&
                                (ptr_q == AW'(TRIG0) || ptr_q == AW'(TRIG1))) begin
                                ers_op_q  <= FOP_ERS_SEC;
                                ers_sec_q <= ptr_q == AW'(TRIG1);
                            end
                        end
                    end else if (bit_q == 4'h9) begin
                        bit_q    <= 4'h0;
                        st_q     <= sda_oe_q ? B_WDAT : B_IGN;
                        sda_oe_q <= 1'b0;
                        if (!sda_oe_q) begin
                            // Refused data cancels the whole transaction
                            cnt_q    <= 5'h00;
                            ers_op_q <= FOP_NONE;
                        end
                    end
                end
                B_RDAT: begin
                    if (bit_q == 4'h8) begin
                        sda_oe_q <= 1'b0;
                        ptr_q    <= ptr_q + AW'(1);
                    end else if (bit_q == 4'h9) begin
                        bit_q <= 4'h0;
                        if (mack_q) begin
                            tx_q     <= fl.rdata;
                            sda_oe_q <= ~fl.rdata[7];
                        end else begin
                            st_q <= B_IGN;
                        end
                    end else begin
                        sda_oe_q <= ~tx_q[3'(4'h7 - bit_q)];
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // ************************************************************
    // Program and erase sequencer
    // ************************************************************
    logic          req_q, seq_sec_q;
    fi2c_fop_t     seq_ers_q, op_q;
    logic [4:0]    seq_n_q, seq_i_q;
    logic [AW-1:0] seq_base_q, faddr_q;
    logic [7:0]    fdata_q;

    assign fl.req   = req_q;
    assign fl.op    = op_q;
    assign fl.addr  = faddr_q;
    assign fl.wdata = fdata_q;
    assign fl.raddr = ptr_q;

    // Erase first, then buffered bytes one by one
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seq_act_q  <= 1'b0;
            seq_ers_q  <= FOP_NONE;
            seq_sec_q  <= 1'b0;
            seq_n_q    <= 5'h00;
            seq_i_q    <= 5'h00;
            seq_base_q <= '0;
            req_q      <= 1'b0;
            op_q       <= FOP_NONE;
            faddr_q    <= '0;
            fdata_q    <= 8'h00;
        end else if (!seq_act_q) begin
            req_q <= 1'b0;
            if (stop_c && (ers_op_q != FOP_NONE || cnt_q != 5'h00)) begin
                seq_act_q  <= 1'b1;
                seq_ers_q  <= ers_op_q;
                seq_sec_q  <= ers_sec_q;
                seq_n_q    <= cnt_q;
                seq_i_q    <= 5'h00;
                seq_base_q <= base_q;
            end
        end else if (req_q || fl.busy) begin
            req_q <= 1'b0;
        end else if (seq_ers_q != FOP_NONE) begin
            req_q     <= 1'b1;
            op_q      <= seq_ers_q;
            faddr_q   <= {seq_sec_q, {(AW - 1){1'b0}}};
            seq_ers_q <= FOP_NONE;
        end else if (seq_i_q < seq_n_q) begin
            req_q   <= 1'b1;
            op_q    <= FOP_PROG;
            faddr_q <= seq_base_q + AW'(seq_i_q);
            fdata_q <= buf_q[seq_i_q[3:0]];
            seq_i_q <= seq_i_q + 5'h01;
        end else begin
            seq_act_q <= 1'b0;
        end
    end

    fi2c_flash #(
        .MEM_BYTES  (MEM_BYTES),
        .AW         (AW),
        .SERASE_CYC (SERASE_CYC),
        .FERASE_CYC (FERASE_CYC)
    ) u_flash (
        .pclk    (pclk),
        .presetn (presetn),
        .fl      (fl)
    );

    // ************************************************************
    // APB slave
    // ************************************************************
    logic [31:0] prdata_q;
    logic        pready_q, pslverr_q;
    logic        map_c;

    assign map_c = paddr == ADDR_CTRL || paddr == ADDR_STAT;

    // One access cycle; read data captured in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q  <= 32'h0000_0000;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            en_q      <= CTRL_EN_RST;
            full_q    <= 1'b0;
        end else begin
            pready_q  <= psel && !penable;
            pslverr_q <= psel && !penable && !map_c;
            if (psel && !penable) begin
                prdata_q <= 32'h0000_0000;
                if (paddr == ADDR_CTRL) begin
                    prdata_q[CTRL_EN]   <= en_q;
                    prdata_q[CTRL_FULL] <= full_q;
                end else if (paddr == ADDR_STAT) begin
                    prdata_q[STAT_BUSY]               <= seq_act_q;
                    prdata_q[STAT_BUS]                <= !st_q[0];
                    prdata_q[STAT_PTR +: AW]          <= ptr_q;
                end
            end
            if (psel && penable && pready_q && pwrite && paddr == ADDR_CTRL) begin
                en_q   <= pwdata[CTRL_EN];
                full_q <= pwdata[CTRL_FULL] | WP_FULL;
            end
        end
    end

    assign prdata  = prdata_q;
    assign pready  = pready_q;
    assign pslverr = pslverr_q;
    assign sda_o   = 1'b0;
    assign sda_oe  = sda_oe_q;

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_dev_ack: assert property (scl_fall && !start_c && !stop_c && st_q == B_DEV && bit_q == 4'h8 &&
        dev_rw && !sh_q[0] |=> sda_oe_q) else $error("address match not acknowledged");
    a_busy_nack: assert property (scl_fall && !start_c && !stop_c && st_q == B_DEV &&
        bit_q == 4'h8 && seq_act_q |=> !sda_oe_q ##1 !sda_oe_q) else $error("acknowledged while busy");
    a_start_stop: assert property ($rose(seq_act_q) |-> $past(stop_c)) else $error("program before stop");
    a_page_max: assert property (cnt_q <= 5'(PAGE_BYTES)) else $error("page buffer overrun");
    a_wp_nack: assert property (scl_fall && !start_c && !stop_c && st_q == B_WDAT && bit_q == 4'h8 &&
        prot_c |=> !sda_oe_q && cnt_q == $past(cnt_q)) else $error("guarded data acknowledged");
    a_fe_guard: assert property (scl_fall && !start_c && !stop_c && st_q == B_DEV && bit_q == 4'h8 &&
        dev_fe && wp_f && !dev_rw |=> !sda_oe_q) else $error("guarded full erase acknowledged");
    a_ro_erase: assert property (READ_ONLY |-> !(req_q && op_q != FOP_PROG))
        else $error("erase in read-only build");
    a_ptr_step: assert property (scl_fall && !start_c && !stop_c && st_q == B_RDAT && bit_q == 4'h8
        |=> ptr_q == $past(ptr_q) + AW'(1)) else $error("read pointer not advanced");

    c_full_erase: cover property (req_q && op_q == FOP_ERS_ALL);
    c_page_full:  cover property (cnt_q == 5'(PAGE_BYTES));
    c_seq_read:   cover property (st_q == B_RDAT && mack_q && bit_q == 4'h9 && scl_fall);
    c_sec_erase:  cover property (req_q && op_q == FOP_ERS_SEC);

endmodule

/* testbench/fi2c_master_model.sv */
`timescale 1ns/1ps
// ****************
// Two-wire master
// ****************
module fi2c_master_model (
    // Clock and bus
    input  wire logic pclk,
    input  wire logic sda,
    output logic      scl   = 1'b1,
    output logic      sda_m = 1'b1
);
    task tk(input int n);
        repeat (n) @(posedge pclk);
    endtask
    // One bit: low phase outlasts the slave's turnaround after SCL falls
    task bt(input logic b, output logic s);
        tk(2);
        sda_m <= b;
        tk(4);
        scl <= 1'b1;
        tk(2);
        s = sda;
        scl <= 1'b0;
    endtask
    // Start or repeated start: SDA falls while SCL high
    task start;
        tk(2);
        sda_m <= 1'b1;
        tk(4);
        scl <= 1'b1;
        tk(4);
        sda_m <= 1'b0;
        tk(4);
        scl <= 1'b0;
    endtask
    // Stop: SDA rises while SCL high, then bus rests
    task stop;
        tk(2);
        sda_m <= 1'b0;
        tk(4);
        scl <= 1'b1;
        tk(4);
        sda_m <= 1'b1;
        tk(8);
    endtask
    // Byte out, MSB first, then ack slot
    task wb(input logic [7:0] d, output logic a);
        logic s;
        for (int i = 7; i >= 0; i--) bt(d[i], s);
        bt(1'b1, s);
        a = ~s;
    endtask
    // Byte in; master acks to go on, nacks to end
    task rb(input logic ak, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) bt(1'b1, d[i]);
        bt(~ak, s);
    endtask
endmodule

/* testbench/fi2c_slave_bench.sv */
`timescale 1ns/1ps
// ****************
// Bench
// ****************
module fi2c_slave_bench;
    import fi2c_pkg::*;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, wp_i = 0, res_v = 0;
    logic        pready, pslverr, sda_oe, sda_o, a, e;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, res, r, exp_q[$];
    logic [7:0]  d[16], base, b;
    logic [2:0]  dev_addr_i = 3'h0;
    wire         scl, sda_m;
    wire         sda = sda_oe ? (sda_m & sda_o) : sda_m;
    int          seed = 42, n_checks = 0, miscompares = 0, n;
    fi2c_slave #(.SERASE_CYC(200), .FERASE_CYC(400)) i_fi2c_slave (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
        .wp_i(wp_i), .dev_addr_i(dev_addr_i));
    fi2c_master_model i_fi2c_master_model (.pclk(pclk), .sda(sda), .scl(scl), .sda_m(sda_m));
    initial forever #50 pclk = ~pclk;
    // APB transfer, held until pready
    task apb(input logic w, input logic [11:0] ad, input logic [31:0] wd);
        psel <= 1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    // Note expectation, then present result
    task nt(input logic [31:0] ex, input logic [31:0] s);
        exp_q.push_back(ex);
        res <= s;
        res_v <= 1;
        @(posedge pclk);
        res_v <= 0;
        @(posedge pclk);
    endtask
    task wk(input logic [7:0] v, input logic ex);
        i_fi2c_master_model.wb(v, a);
        nt(ex, a);
    endtask
    task st;
        i_fi2c_master_model.start;
    endtask
    task sp;
        i_fi2c_master_model.stop;
    endtask
    // Acknowledge polling until the sequencer is idle
    task poll;
        n = 0;
        do begin
            st;
            i_fi2c_master_model.wb(8'ha0, a);
            sp;
            n++;
        end while (!a && n < 400);
        nt(1, a);
    endtask
    task chk(input logic [31:0] s, input logic [31:0] ex);
        n_checks++;
        if (s !== ex) begin
            miscompares++;
            $display("unexpected result: expected %h seen %h", ex, s);
        end
    endtask
    // Watcher: oldest note against each result
    always @(posedge pclk) if (res_v === 1'b1) chk(res, exp_q.pop_front());
    task give_verdict;
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        #5_000_000;
        miscompares++;
        give_verdict;
    end
    // Main sequence
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1;
        repeat (4) @(posedge pclk);
        apb(0, ADDR_CTRL, 0);
        nt(1, r);
        apb(0, 12'h008, 0);
        nt(1, e);
        wp_i <= 1;
        st;
        wk(8'hae, 0);
        sp;
        wp_i <= 0;
        st;
        wk(8'hae, 1);
        sp;
        st;
        wk(8'ha0, 0);
        sp;
        poll;
        base = 8'($random(seed));
        st;
        wk(8'ha0, 1);
        wk(base, 1);
        for (int i = 0; i < 16; i++) begin
            d[i] = 8'($random(seed));
            wk(d[i], 1);
        end
        apb(0, ADDR_STAT, 0);
        nt(0, r[0]);
        sp;
        poll;
        st;
        wk(8'ha0, 1);
        wk(base, 1);
        st;
        wk(8'ha1, 1);
        for (int i = 0; i < 16; i++) begin
            i_fi2c_master_model.rb(i < 15, b);
            nt(d[i], b);
        end
        sp;
        st;
        wk(8'ha1, 1);
        i_fi2c_master_model.rb(0, b);
        nt(ERASED_BYTE, b);
        sp;
        apb(1, ADDR_CTRL, 3);
        wp_i <= 1;
        st;
        wk(8'ha0, 1);
        wk(base, 1);
        wk(8'h00, 0);
        sp;
        give_verdict;
    end
endmodule
